// File: mseq_pkg.sv
`default_nettype none
package mseq_pkg;
	// Register byte offsets.
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_TIMER = 8'h04;
	localparam logic [7:0] OFS_STATUS = 8'h08;
	// Control register field positions.
	localparam int CTRL_LAUNCH = 0;
	localparam int CTRL_HALT = 1;
	localparam int CTRL_IDLE_POWER = 2;
	localparam int CTRL_LAUNCH_EXIT = 3;
	localparam int CTRL_LP_TARGET = 5;
	localparam int CTRL_IDLE_EXIT = 6;
	localparam int CTRL_TX_EXIT = 7;
	localparam int CTRL_RX_EXIT = 8;
	localparam int CTRL_TIMEOUT_EXIT = 11;
	localparam int CTRL_GOT_FRAME_EXIT = 13;
	localparam int CTRL_BASE_MODE = 16;
	localparam int CTRL_CHECK_ON = 17;
	localparam int CTRL_AUTOFLUSH = 18;
	localparam logic [31:0] CTRL_WMASK = 32'h0007_FFFC;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	// Timer register field positions.
	localparam int TMR_STEP1 = 0;
	localparam int TMR_STEP2 = 2;
	localparam int TMR_MULT1 = 8;
	localparam int TMR_MULT2 = 16;
	localparam logic [31:0] TMR_WMASK = 32'h00FF_FF0F;
	localparam logic [31:0] TMR_RESET = 32'h0000_0000;
	// Status register field positions.
	localparam int STS_STATE = 0;
	localparam int STS_CHIP = 4;
	localparam int STS_INITIAL = 8;
	localparam int STS_TIMER_ON = 9;
	localparam int STS_TIMER_PHASE = 10;
	// Timer resolutions and the clock period.
	localparam int CLK_NS = 20;
	localparam int STEP1_NS = 64000;
	localparam int STEP2_NS = 4100000;
	localparam int STEP3_NS = 262000000;
	localparam int STEP1_CYC = STEP1_NS / CLK_NS;
	localparam int STEP2_CYC = STEP2_NS / CLK_NS;
	localparam int STEP3_CYC = STEP3_NS / CLK_NS;
	// Selection codes.
	localparam logic [1:0] STEP_OFF = 2'h0;
	localparam logic [1:0] LX_LP = 2'h0;
	localparam logic [1:0] LX_RX = 2'h1;
	localparam logic [1:0] LX_TX = 2'h2;
	localparam logic [2:0] RX_PAY_FRAME = 3'h1;
	localparam logic [2:0] RX_PAY_LP = 3'h2;
	localparam logic [2:0] RX_CHECK = 3'h3;
	localparam logic [2:0] RX_LEVEL_OFF = 3'h4;
	localparam logic [2:0] RX_PATTERN_OFF = 3'h5;
	localparam logic [2:0] RX_PREAMBLE_OFF = 3'h6;
	localparam logic [1:0] TO_RELAUNCH = 2'h0;
	localparam logic [1:0] TO_TX = 2'h1;
	localparam logic [1:0] TO_LP = 2'h2;
	localparam logic [2:0] GF_OFF = 3'h0;
	localparam logic [2:0] GF_TX_DRAINED = 3'h1;
	localparam logic [2:0] GF_LP = 3'h2;
	localparam logic [2:0] GF_RX_SYNTH = 3'h3;
	localparam logic [2:0] GF_RX = 3'h4;
	typedef enum logic [3:0] {
		SEQ_OFF, SEQ_WAIT_LEVEL, SEQ_IDLE, SEQ_TX, SEQ_RX,
		SEQ_GOT_FRAME, SEQ_LP_SELECT, SEQ_RX_TIMEOUT, SEQ_SYNTH
	} mseq_state_t;
	typedef enum logic [2:0] {
		MODE_SLEEP, MODE_STANDBY, MODE_SYNTH, MODE_TX, MODE_RX
	} mseq_mode_t;
endpackage
`default_nettype wire

// File: mseq_top.sv
// Notes on behaviour
// - Idle power select picks Standby or Sleep.
// - Launch exit code steers the first move.
// - Low-power target picks Off or Idle.
// - Launch mode recorded, restored on low-power Off.
// - Idle and Transmit exits follow their bits.
// - Receive exit code picks event and target.
// - Failed check in code 011 takes timeout path unless autoflush is on.
// - Second timer in Receive goes low-power.
// - Timeout exit code picks target after timeout.
// - Any of three timeouts counts as timeout.
// - Got-frame exit code picks next state.
// - Two interval timers feed sequencer triggers.
// - First timer fires after launch or second.
// - Second timer fires after the first.
// - Timers alternate regardless; disabled one stops chain.
// - Step code times multiplier gives interval.
// - Halt forces Off from any state.
// - Idle ignores all but first timer and halt.
//
// The APB slave port and the address map were decided locally.
`default_nettype none
module mseq_top #(
	parameter int STEP1_CYCLES = mseq_pkg::STEP1_CYC,
	parameter int STEP2_CYCLES = mseq_pkg::STEP2_CYC,
	parameter int STEP3_CYCLES = mseq_pkg::STEP3_CYC
) (
	// Clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	// APB slave.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata_q,
	output logic pready_q,
	output logic pslverr_q,
	// Radio events, one-cycle pulses.
	input wire logic frame_sent_event,
	input wire logic payload_available_event,
	input wire logic check_pass_event,
	input wire logic level_event,
	input wire logic pattern_match_event,
	input wire logic preamble_found_event,
	input wire logic level_timeout_event,
	input wire logic preamble_timeout_event,
	input wire logic pattern_timeout_event,
	input wire logic queue_level_event,
	input wire logic queue_drained_event,
	input wire logic freq_changed,
	// Chip control.
	output mseq_pkg::mseq_mode_t chip_mode_q,
	output logic receiver_relaunch_q,
	output logic first_timer_event_q,
	output logic second_timer_event_q
);
	logic [31:0] ctrl_q, ctrl_d, tmr_q, tmr_d, prdata_d;
	logic pready_d, pslverr_d, acc, wr, launch, halt, receive_timeout_event;
	mseq_pkg::mseq_state_t state_q, state_d;
	mseq_pkg::mseq_mode_t chip_mode_d, initial_q, initial_d, off_mode_q, off_mode_d;
	logic relaunch_d, t1_d, t2_d, tmr_on_q, tmr_on_d, phase_q, phase_d;
	logic [23:0] cyc_q, cyc_d;
	logic [7:0] cnt_q, cnt_d, mult;
	logic [1:0] step, step1, step2;

	function automatic logic [23:0] step_cycles(input logic [1:0] code);
		unique case (code)
			2'h1: step_cycles = 24'(STEP1_CYCLES);
			2'h2: step_cycles = 24'(STEP2_CYCLES);
			2'h3: step_cycles = 24'(STEP3_CYCLES);
			default: step_cycles = 24'h00_0001;
		endcase
	endfunction

	function automatic mseq_pkg::mseq_mode_t low_power(input logic sleep);
		low_power = sleep ? mseq_pkg::MODE_SLEEP : mseq_pkg::MODE_STANDBY;
	endfunction

	// One wait state keeps read data registered; a transfer ends on the second access cycle.
	assign acc = psel & penable & pready_q;
	assign wr = acc & pwrite;
	assign launch = wr & (paddr == mseq_pkg::OFS_CTRL) & pwdata[mseq_pkg::CTRL_LAUNCH]
		& (state_q == mseq_pkg::SEQ_OFF);
	assign halt = wr & (paddr == mseq_pkg::OFS_CTRL) & pwdata[mseq_pkg::CTRL_HALT];
	assign receive_timeout_event = level_timeout_event | preamble_timeout_event
		| pattern_timeout_event;
	assign step1 = tmr_q[mseq_pkg::TMR_STEP1 +: 2];
	assign step2 = tmr_q[mseq_pkg::TMR_STEP2 +: 2];

	always_comb begin
		ctrl_d = ctrl_q;
		tmr_d = tmr_q;
		off_mode_d = off_mode_q;
		pready_d = psel & penable & ~pready_q;
		pslverr_d = 1'b0;
		prdata_d = 32'h0000_0000;
		if (psel & penable & ~pready_q) begin
			unique case (paddr)
				mseq_pkg::OFS_CTRL: prdata_d = ctrl_q;
				mseq_pkg::OFS_TIMER: prdata_d = tmr_q;
				mseq_pkg::OFS_STATUS: begin
					prdata_d[mseq_pkg::STS_STATE +: 4] = state_q;
					prdata_d[mseq_pkg::STS_CHIP +: 3] = chip_mode_q;
					prdata_d[mseq_pkg::STS_INITIAL] = (initial_q == mseq_pkg::MODE_SLEEP);
					prdata_d[mseq_pkg::STS_TIMER_ON] = tmr_on_q;
					prdata_d[mseq_pkg::STS_TIMER_PHASE] = phase_q;
				end
				default: pslverr_d = 1'b1;
			endcase
		end
		if (wr & (paddr == mseq_pkg::OFS_CTRL)) begin
			ctrl_d = pwdata & mseq_pkg::CTRL_WMASK;
			off_mode_d = low_power(pwdata[mseq_pkg::CTRL_BASE_MODE]);
		end
		if (wr & (paddr == mseq_pkg::OFS_TIMER)) begin
			tmr_d = pwdata & mseq_pkg::TMR_WMASK;
		end
		if ((state_q == mseq_pkg::SEQ_LP_SELECT) & ~ctrl_q[mseq_pkg::CTRL_LP_TARGET]) begin
			off_mode_d = initial_q;
		end
	end

	// Timer chain: one cycle counter and one multiplier counter serve whichever timer is running, since they never overlap.
	always_comb begin
		tmr_on_d = tmr_on_q;
		phase_d = phase_q;
		cyc_d = cyc_q;
		cnt_d = cnt_q;
		t1_d = 1'b0;
		t2_d = 1'b0;
		step = phase_q ? step2 : step1;
		mult = phase_q ? tmr_q[mseq_pkg::TMR_MULT2 +: 8] : tmr_q[mseq_pkg::TMR_MULT1 +: 8];
		if (halt) begin
			tmr_on_d = 1'b0;
		end else if (launch) begin
			tmr_on_d = (step1 != mseq_pkg::STEP_OFF);
			phase_d = 1'b0;
			cyc_d = 24'h00_0000;
			cnt_d = 8'h00;
		end else if (tmr_on_q) begin
			if (cyc_q + 24'h00_0001 >= step_cycles(step)) begin
				cyc_d = 24'h00_0000;
				if (cnt_q + 8'h01 >= mult) begin
					cnt_d = 8'h00;
					t1_d = ~phase_q;
					t2_d = phase_q;
					phase_d = ~phase_q;
					tmr_on_d = ((phase_q ? step1 : step2) != mseq_pkg::STEP_OFF);
				end else begin
					cnt_d = cnt_q + 8'h01;
				end
			end else begin
				cyc_d = cyc_q + 24'h00_0001;
			end
		end
	end

	// Sequencer next state; the timers advance whatever state this machine is in.
	always_comb begin
		state_d = state_q;
		initial_d = initial_q;
		relaunch_d = 1'b0;
		unique case (state_q)
			mseq_pkg::SEQ_OFF: begin
				if (launch) begin
					initial_d = low_power(ctrl_q[mseq_pkg::CTRL_BASE_MODE]);
					unique case (ctrl_q[mseq_pkg::CTRL_LAUNCH_EXIT +: 2])
						mseq_pkg::LX_LP: state_d = mseq_pkg::SEQ_LP_SELECT;
						mseq_pkg::LX_RX: state_d = mseq_pkg::SEQ_RX;
						mseq_pkg::LX_TX: state_d = mseq_pkg::SEQ_TX;
						default: state_d = mseq_pkg::SEQ_WAIT_LEVEL;
					endcase
				end
			end
			mseq_pkg::SEQ_WAIT_LEVEL: begin
				if (queue_level_event) state_d = mseq_pkg::SEQ_TX;
			end
			mseq_pkg::SEQ_IDLE: begin
				if (first_timer_event_q) begin
					state_d = ctrl_q[mseq_pkg::CTRL_IDLE_EXIT] ? mseq_pkg::SEQ_RX
						: mseq_pkg::SEQ_TX;
				end
			end
			mseq_pkg::SEQ_TX: begin
				if (frame_sent_event) begin
					state_d = ctrl_q[mseq_pkg::CTRL_TX_EXIT] ? mseq_pkg::SEQ_RX
						: mseq_pkg::SEQ_LP_SELECT;
				end
			end
			mseq_pkg::SEQ_RX: begin
				if (second_timer_event_q) begin
					state_d = mseq_pkg::SEQ_LP_SELECT;
				end else if (receive_timeout_event) begin
					state_d = mseq_pkg::SEQ_RX_TIMEOUT;
				end else begin
					unique case (ctrl_q[mseq_pkg::CTRL_RX_EXIT +: 3])
						mseq_pkg::RX_PAY_FRAME:
							if (payload_available_event) state_d = mseq_pkg::SEQ_GOT_FRAME;
						mseq_pkg::RX_PAY_LP:
							if (payload_available_event) state_d = mseq_pkg::SEQ_LP_SELECT;
						mseq_pkg::RX_CHECK: begin
							if (check_pass_event) begin
								state_d = mseq_pkg::SEQ_GOT_FRAME;
							end else if (payload_available_event & ctrl_q[mseq_pkg::CTRL_CHECK_ON]
								& ~ctrl_q[mseq_pkg::CTRL_AUTOFLUSH]) begin
								state_d = mseq_pkg::SEQ_RX_TIMEOUT;
							end
						end
						mseq_pkg::RX_LEVEL_OFF: if (level_event) state_d = mseq_pkg::SEQ_OFF;
						mseq_pkg::RX_PATTERN_OFF:
							if (pattern_match_event) state_d = mseq_pkg::SEQ_OFF;
						mseq_pkg::RX_PREAMBLE_OFF:
							if (preamble_found_event) state_d = mseq_pkg::SEQ_OFF;
						default: state_d = mseq_pkg::SEQ_RX;
					endcase
				end
			end
			mseq_pkg::SEQ_RX_TIMEOUT: begin
				unique case (ctrl_q[mseq_pkg::CTRL_TIMEOUT_EXIT +: 2])
					mseq_pkg::TO_RELAUNCH: begin
						state_d = mseq_pkg::SEQ_RX;
						relaunch_d = 1'b1;
					end
					mseq_pkg::TO_TX: state_d = mseq_pkg::SEQ_TX;
					mseq_pkg::TO_LP: state_d = mseq_pkg::SEQ_LP_SELECT;
					default: state_d = mseq_pkg::SEQ_OFF;
				endcase
			end
			mseq_pkg::SEQ_GOT_FRAME: begin
				unique case (ctrl_q[mseq_pkg::CTRL_GOT_FRAME_EXIT +: 3])
					mseq_pkg::GF_OFF: state_d = mseq_pkg::SEQ_OFF;
					mseq_pkg::GF_TX_DRAINED: if (queue_drained_event) state_d = mseq_pkg::SEQ_TX;
					mseq_pkg::GF_LP: state_d = mseq_pkg::SEQ_LP_SELECT;
					mseq_pkg::GF_RX_SYNTH:
						state_d = freq_changed ? mseq_pkg::SEQ_SYNTH : mseq_pkg::SEQ_RX;
					mseq_pkg::GF_RX: state_d = mseq_pkg::SEQ_RX;
					default: state_d = mseq_pkg::SEQ_GOT_FRAME;
				endcase
			end
			mseq_pkg::SEQ_LP_SELECT: begin
				state_d = ctrl_q[mseq_pkg::CTRL_LP_TARGET] ? mseq_pkg::SEQ_IDLE
					: mseq_pkg::SEQ_OFF;
			end
			mseq_pkg::SEQ_SYNTH: state_d = mseq_pkg::SEQ_RX;
			default: state_d = mseq_pkg::SEQ_OFF;
		endcase
		if (halt) begin
			state_d = mseq_pkg::SEQ_OFF;
			relaunch_d = 1'b0;
		end
	end

	// The transitory states SEQ_LP_SELECT and SEQ_RX_TIMEOUT keep the previous chip mode, so the radio sees no glitch.
	always_comb begin
		chip_mode_d = chip_mode_q;
		unique case (state_d)
			mseq_pkg::SEQ_OFF: chip_mode_d = off_mode_d;
			mseq_pkg::SEQ_WAIT_LEVEL: chip_mode_d = initial_d;
			mseq_pkg::SEQ_IDLE: chip_mode_d = low_power(ctrl_q[mseq_pkg::CTRL_IDLE_POWER]);
			mseq_pkg::SEQ_TX: chip_mode_d = mseq_pkg::MODE_TX;
			mseq_pkg::SEQ_RX, mseq_pkg::SEQ_GOT_FRAME: chip_mode_d = mseq_pkg::MODE_RX;
			mseq_pkg::SEQ_SYNTH: chip_mode_d = mseq_pkg::MODE_SYNTH;
			default: chip_mode_d = chip_mode_q;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= mseq_pkg::CTRL_RESET;
			tmr_q <= mseq_pkg::TMR_RESET;
			prdata_q <= 32'h0000_0000;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			state_q <= mseq_pkg::SEQ_OFF;
			initial_q <= mseq_pkg::MODE_STANDBY;
			off_mode_q <= mseq_pkg::MODE_STANDBY;
			chip_mode_q <= mseq_pkg::MODE_STANDBY;
			receiver_relaunch_q <= 1'b0;
			tmr_on_q <= 1'b0;
			phase_q <= 1'b0;
			cyc_q <= 24'h00_0000;
			cnt_q <= 8'h00;
			first_timer_event_q <= 1'b0;
			second_timer_event_q <= 1'b0;
		end else begin
			ctrl_q <= ctrl_d;
			tmr_q <= tmr_d;
			prdata_q <= prdata_d;
			pready_q <= pready_d;
			pslverr_q <= pslverr_d;
			state_q <= state_d;
			initial_q <= initial_d;
			off_mode_q <= off_mode_d;
			chip_mode_q <= chip_mode_d;
			receiver_relaunch_q <= relaunch_d;
			tmr_on_q <= tmr_on_d;
			phase_q <= phase_d;
			cyc_q <= cyc_d;
			cnt_q <= cnt_d;
			first_timer_event_q <= t1_d;
			second_timer_event_q <= t2_d;
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	AST_HALT_OFF: assert property (halt |=> state_q == mseq_pkg::SEQ_OFF)
		else $error("halt did not reach off");
	AST_IDLE_MODE: assert property (state_q == mseq_pkg::SEQ_IDLE |->
		chip_mode_q == low_power($past(ctrl_q[mseq_pkg::CTRL_IDLE_POWER])))
		else $error("idle chip mode wrong");
	AST_IDLE_HOLD: assert property (state_q == mseq_pkg::SEQ_IDLE && !first_timer_event_q
		&& !halt |=> state_q == mseq_pkg::SEQ_IDLE) else $error("idle left without timer");
	AST_IDLE_EXIT: assert property (state_q == mseq_pkg::SEQ_IDLE && first_timer_event_q
		&& !halt |=> state_q == ($past(ctrl_q[mseq_pkg::CTRL_IDLE_EXIT]) ? mseq_pkg::SEQ_RX
		: mseq_pkg::SEQ_TX)) else $error("idle exit wrong");
	AST_RX_T2: assert property (state_q == mseq_pkg::SEQ_RX && second_timer_event_q
		&& !halt |=> state_q == mseq_pkg::SEQ_LP_SELECT) else $error("second timer ignored");
	AST_RX_TIMEOUT: assert property (state_q == mseq_pkg::SEQ_RX && !second_timer_event_q
		&& receive_timeout_event && !halt |=> state_q == mseq_pkg::SEQ_RX_TIMEOUT)
		else $error("timeout ignored");
	AST_RELAUNCH: assert property (state_q == mseq_pkg::SEQ_RX_TIMEOUT && !halt
		&& ctrl_q[mseq_pkg::CTRL_TIMEOUT_EXIT +: 2] == mseq_pkg::TO_RELAUNCH
		|=> state_q == mseq_pkg::SEQ_RX && receiver_relaunch_q) else $error("no relaunch");
	AST_LP_OFF: assert property (state_q == mseq_pkg::SEQ_LP_SELECT && !halt
		&& !ctrl_q[mseq_pkg::CTRL_LP_TARGET] && !wr |=> state_q == mseq_pkg::SEQ_OFF
		&& chip_mode_q == initial_q) else $error("initial mode not restored");
	AST_TX_MODE: assert property (state_q == mseq_pkg::SEQ_TX |->
		chip_mode_q == mseq_pkg::MODE_TX) else $error("transmit mode missing");
	AST_ALTERNATE: assert property (first_timer_event_q |-> !second_timer_event_q
		##1 !first_timer_event_q) else $error("timers fired together");
	COV_IDLE_TX: cover property (state_q == mseq_pkg::SEQ_IDLE ##1 state_q == mseq_pkg::SEQ_TX);
	COV_GOT_FRAME: cover property (state_q == mseq_pkg::SEQ_GOT_FRAME);
	COV_T2: cover property (second_timer_event_q);
	COV_TIMEOUT: cover property (state_q == mseq_pkg::SEQ_RX_TIMEOUT);
endmodule
`default_nettype wire

// File: tb_mseq_top.sv
`default_nettype none
module tb_mseq_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, frq = 0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000, prdata_q, r;
	logic pready_q, pslverr_q, e, relaunch, t1, t2;
	logic [10:0] ev = 11'h000;
	mseq_pkg::mseq_mode_t chip_mode_q;
	int error_cnt = 0, check_count = 0, seed = 32, cyc = 0, rl_cnt = 0;
	int q1[$], q2[$];
	mseq_top #(.STEP1_CYCLES(4), .STEP2_CYCLES(8), .STEP3_CYCLES(16)) dut (.pclk(pclk),
		.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata_q(prdata_q), .pready_q(pready_q), .pslverr_q(pslverr_q),
		.level_timeout_event(ev[0]), .preamble_timeout_event(ev[1]),
		.pattern_timeout_event(ev[2]), .payload_available_event(ev[3]),
		.check_pass_event(ev[4]), .level_event(ev[5]), .pattern_match_event(ev[6]),
		.preamble_found_event(ev[7]), .frame_sent_event(ev[8]), .queue_level_event(ev[9]),
		.queue_drained_event(ev[10]), .freq_changed(frq), .chip_mode_q(chip_mode_q),
		.receiver_relaunch_q(relaunch), .first_timer_event_q(t1), .second_timer_event_q(t2));
	initial begin
		forever #10 pclk = ~pclk;
	end
	// Pulse times are logged so interval checks never depend on polling latency.
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (relaunch === 1'b1) rl_cnt <= rl_cnt + 1;
		if (t1 === 1'b1) q1.push_back(cyc);
		if (t2 === 1'b1) q2.push_back(cyc);
	end
	task automatic print_verdict();
		$display("checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready_q !== 1'b1 && n < 20);
		if (n >= 20) begin
			error_cnt++;
			print_verdict();
		end
		r = prdata_q;
		e = pslverr_q;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic pulse(input int i);
		ev <= 11'h001 << i;
		@(posedge pclk);
		ev <= 11'h000;
		repeat (4) @(posedge pclk);
	endtask
	// Reads the status word and compares state, and chip mode unless m is negative.
	task automatic status(input int s, input int m);
		apb(1'b0, mseq_pkg::OFS_STATUS, 32'h0000_0000);
		chk({28'h000_0000, r[3:0]}, s);
		if (m >= 0) chk({29'h0000_0000, chip_mode_q}, m);
	endtask
	function automatic int model(input int rx, to, lp, ev, ck, af, output int vlp, output int rl);
		int s;
		s = 4;
		vlp = 0;
		rl = 0;
		if (ev < 3 || (ev == 3 && rx == 3 && ck == 1 && af == 0)) begin
			s = (to == 0) ? 4 : (to == 1) ? 3 : (to == 2) ? 6 : 0;
			rl = (to == 0);
		end else if (ev == 3 && rx == 1) s = 5;
		else if (ev == 3 && rx == 2) s = 6;
		else if (ev == 4 && rx == 3) s = 5;
		else if (rx >= 4 && rx <= 6 && ev == rx + 1) s = 0;
		if (s == 6) begin
			vlp = 1;
			s = lp ? 2 : 0;
		end
		return s;
	endfunction
	initial begin
		logic [31:0] c, d;
		int rx, to, lp, ip, ck, af, bm, s, vlp, rl, m, r0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, mseq_pkg::OFS_CTRL, 32'h0000_0000);
		chk(r, mseq_pkg::CTRL_RESET);
		apb(1'b0, mseq_pkg::OFS_TIMER, 32'h0000_0000);
		chk(r, mseq_pkg::TMR_RESET);
		status(0, 1);
		apb(1'b0, 8'h0C, 32'h0000_0000);
		chk({31'h0, e}, 1);
		d = $random(seed) & 32'hFFFF_FFFC;
		apb(1'b1, mseq_pkg::OFS_CTRL, d);
		apb(1'b0, mseq_pkg::OFS_CTRL, 32'h0000_0000);
		chk(r, d & mseq_pkg::CTRL_WMASK);
		apb(1'b1, mseq_pkg::OFS_TIMER, 32'h0000_0000);
		for (int i = 0; i < 64; i++) begin
			rx = i % 8;
			d = $random(seed);
			to = d[7:6];
			lp = d[0];
			ip = d[1];
			ck = d[2];
			af = d[3];
			bm = d[4];
			frq <= d[5];
			c = (ip << 2) | (1 << 3) | (lp << 5) | (rx << 8) | (to << 11) | (1 << 13);
			c = c | (bm << 16) | (ck << 17) | (af << 18);
			apb(1'b1, mseq_pkg::OFS_CTRL, c);
			// Launch and halt always go in separate writes.
			apb(1'b1, mseq_pkg::OFS_CTRL, c | 32'h0000_0001);
			status(4, 4);
			r0 = rl_cnt;
			s = model(rx, to, lp, i / 8, ck, af, vlp, rl);
			pulse(i / 8);
			m = (s == 3) ? 3 : (s >= 4) ? 4 : (s == 2) ? (ip ? 0 : 1) : (vlp ? (bm ? 0 : 1) : -1);
			status(s, m);
			chk(rl_cnt - r0, rl);
			apb(1'b1, mseq_pkg::OFS_CTRL, c | 32'h0000_0002);
			status(0, -1);
		end
		// Launch code 11 waits for the queue level; a later base-mode write must not win.
		apb(1'b1, mseq_pkg::OFS_CTRL, 32'h0001_0018);
		apb(1'b1, mseq_pkg::OFS_CTRL, 32'h0001_0019);
		status(1, 0);
		pulse(9);
		status(3, 3);
		apb(1'b1, mseq_pkg::OFS_CTRL, 32'h0000_0018);
		pulse(8);
		status(0, 0);
		frq <= 1'b1;
		for (int g = 0; g < 5; g++) begin
			c = 32'h0000_0128 | (g << 13);
			apb(1'b1, mseq_pkg::OFS_CTRL, c);
			apb(1'b1, mseq_pkg::OFS_CTRL, c | 32'h0000_0001);
			pulse(3);
			if (g == 1) begin
				status(5, 4);
				pulse(10);
			end
			s = (g == 0) ? 0 : (g == 1) ? 3 : (g == 2) ? 2 : 4;
			m = (g == 0) ? -1 : (g == 1) ? 3 : (g == 2) ? 1 : 4;
			status(s, m);
			apb(1'b1, mseq_pkg::OFS_CTRL, c | 32'h0000_0002);
		end
		apb(1'b1, mseq_pkg::OFS_CTRL, 32'h0000_00A4);
		apb(1'b1, mseq_pkg::OFS_CTRL, 32'h0000_00A5);
		status(2, 0);
		for (int i = 0; i < 11; i++) pulse(i);
		status(2, 0);
		apb(1'b1, mseq_pkg::OFS_CTRL, 32'h0000_0092);
		apb(1'b1, mseq_pkg::OFS_CTRL, 32'h0000_0091);
		status(3, 3);
		pulse(8);
		status(4, 4);
		apb(1'b1, mseq_pkg::OFS_CTRL, 32'h0000_0002);
		apb(1'b1, mseq_pkg::OFS_TIMER, 32'h0003_0205);
		apb(1'b1, mseq_pkg::OFS_CTRL, 32'h0000_0060);
		q1.delete();
		q2.delete();
		apb(1'b1, mseq_pkg::OFS_CTRL, 32'h0000_0061);
		r0 = cyc;
		repeat (70) @(posedge pclk);
		apb(1'b1, mseq_pkg::OFS_CTRL, 32'h0000_0062);
		if (q1.size() < 2 || q2.size() < 1) chk(0, 1);
		else begin
			chk(q1[0] - r0, 8);
			chk(q2[0] - q1[0], 12);
			chk(q1[1] - q2[0], 8);
		end
		apb(1'b1, mseq_pkg::OFS_TIMER, 32'h0000_0201);
		q1.delete();
		q2.delete();
		apb(1'b1, mseq_pkg::OFS_CTRL, 32'h0000_0061);
		repeat (70) @(posedge pclk);
		chk(q1.size(), 1);
		chk(q2.size(), 0);
		// Slower step codes: 8 and 16 cycles per step with unit multipliers.
		apb(1'b1, mseq_pkg::OFS_CTRL, 32'h0000_0062);
		apb(1'b1, mseq_pkg::OFS_TIMER, 32'h0001_010E);
		q1.delete();
		q2.delete();
		apb(1'b1, mseq_pkg::OFS_CTRL, 32'h0000_0061);
		r0 = cyc;
		repeat (70) @(posedge pclk);
		if (q1.size() < 2 || q2.size() < 1) chk(0, 1);
		else begin
			chk(q1[0] - r0, 8);
			chk(q2[0] - q1[0], 16);
			chk(q1[1] - q2[0], 8);
		end
		print_verdict();
	end
endmodule
`default_nettype wire
